//--- src/nfc_pkg.sv
// Package for the NAND host controller: command codes, address layout,
// page geometry and strobe timing counts.
// Assumes a 125 MHz core clock driving all controller logic.
package nfc_pkg;
  // Clock and timing
  localparam int CLK_MHZ          = 125;
  localparam int T_WP_NS          = 12;   // Input strobe low time
  localparam int T_WH_NS          = 10;   // Input strobe high time
  localparam int T_RP_NS          = 12;   // Output strobe low time
  localparam int T_REA_NS         = 20;   // Access time after output strobe falls
  localparam int T_WHR_NS         = 60;   // Input strobe high to output strobe low
  localparam int T_WB_NS          = 100;  // Input strobe high to busy
  localparam int T_WW_NS          = 100;  // Write protect high to input strobe low
  localparam int T_SETUP_NS       = 20;   // Chip select and latch setup
  localparam int T_TR_NS          = 25;   // Ready to strobe fall (tRR/tRW)
  // Cycle counts, least times rounded up; CYC_RP is the access time rounded up plus one
  localparam int CYC_WP   = (T_WP_NS   * CLK_MHZ + 999) / 1000;
  localparam int CYC_WH   = (T_WH_NS   * CLK_MHZ + 999) / 1000;
  localparam int CYC_RP   = (T_REA_NS  * CLK_MHZ + 999) / 1000 + 1;
  localparam int CYC_WHR  = (T_WHR_NS  * CLK_MHZ + 999) / 1000;
  localparam int CYC_WB   = (T_WB_NS   * CLK_MHZ + 999) / 1000;
  localparam int CYC_WW   = (T_WW_NS   * CLK_MHZ + 999) / 1000;
  localparam int CYC_SU   = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_TR   = (T_TR_NS   * CLK_MHZ + 999) / 1000;
  localparam int TCNT_W   = 5;
  // Address layout
  localparam int ADDR_CYCLES      = 5;
  localparam int COL_W            = 12;
  localparam int ROW_W            = 17;
  localparam int PAGE_W           = 6;
  localparam int BLOCK_W          = 11;
  localparam int PAGE_BYTES       = 2176;
  localparam int MAIN_BYTES       = 2048;
  localparam int SPARE_BYTES      = 128;
  localparam int PAGES_PER_BLOCK  = 64;
  localparam int LEN_W            = 12;
  // Command codes
  localparam logic [7:0] CMD_READ1     = 8'h00;
  localparam logic [7:0] CMD_READ2     = 8'h30;
  localparam logic [7:0] CMD_RCOL1     = 8'h05;
  localparam logic [7:0] CMD_RCOL2     = 8'he0;
  localparam logic [7:0] CMD_RCACHE    = 8'h31;
  localparam logic [7:0] CMD_RLAST     = 8'h3f;
  localparam logic [7:0] CMD_PROG1     = 8'h80;
  localparam logic [7:0] CMD_WCOL      = 8'h85;
  localparam logic [7:0] CMD_PROG2     = 8'h10;
  localparam logic [7:0] CMD_PCACHE    = 8'h15;
  localparam logic [7:0] CMD_PMULTI    = 8'h11;
  localparam logic [7:0] CMD_PROG1B    = 8'h81;
  localparam logic [7:0] CMD_RCOPY     = 8'h3a;
  localparam logic [7:0] CMD_PCOPY     = 8'h8c;
  localparam logic [7:0] CMD_ERASE1    = 8'h60;
  localparam logic [7:0] CMD_ERASE2    = 8'hd0;
  localparam logic [7:0] CMD_ID        = 8'h90;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_MSTATUS   = 8'h71;
  localparam logic [7:0] CMD_RESET     = 8'hff;
  // Status bit positions
  localparam int ST_READY_BIT     = 6;
  localparam int ST_FAIL_BIT      = 0;
  // Micro-operation kinds sent to the pin engine
  typedef enum logic [2:0] {
    NFC_OP_CMD  = 3'h0,
    NFC_OP_ADDR = 3'h1,
    NFC_OP_WR   = 3'h2,
    NFC_OP_RD   = 3'h3,
    NFC_OP_WAIT = 3'h4
  } nfc_op_t;
  // Sequences offered to the user
  typedef enum logic [2:0] {
    NFC_SEQ_READ   = 3'h0,  // 00, addr, 30, wait, read len
    NFC_SEQ_PROG   = 3'h1,  // 80, addr, write len, confirm, wait
    NFC_SEQ_ERASE  = 3'h2,  // 60, row, d0, wait
    NFC_SEQ_STATUS = 3'h3,  // 70 or 71, read one byte
    NFC_SEQ_RESET  = 3'h4,  // ff, wait
    NFC_SEQ_ID     = 3'h5,  // 90, one addr, read len
    NFC_SEQ_RCOL   = 3'h6,  // 05, col, e0, read len
    NFC_SEQ_RAW    = 3'h7   // one command cycle of any code
  } nfc_seq_t;
  // Pack the five address cycles
  function automatic logic [7:0] nfc_addr_byte(input logic [COL_W-1:0] col,
                                               input logic [ROW_W-1:0] row,
                                               input logic [2:0] idx);
    unique case (idx)
      3'd0:    nfc_addr_byte = col[7:0];
      3'd1:    nfc_addr_byte = {4'h0, col[11:8]};
      3'd2:    nfc_addr_byte = row[7:0];
      3'd3:    nfc_addr_byte = row[15:8];
      default: nfc_addr_byte = {7'h00, row[16]};
    endcase
  endfunction
endpackage

//--- src/nfc_op_if.sv
// Interface between the sequencer and the pin engine.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
interface nfc_op_if;
  import nfc_pkg::*;
  logic       valid;   // Micro-operation offered
  logic       ready;   // Engine takes it
  nfc_op_t    op;      // Kind of cycle
  logic [7:0] wdata;   // Byte for command, address or data-in
  logic       done;    // Pulse: micro-operation finished
  logic [7:0] rdata;   // Byte read, valid with done on a read
  modport seq (output valid, op, wdata, input ready, done, rdata);
  modport eng (input valid, op, wdata, output ready, done, rdata);
endinterface

//--- src/nfc_pin_engine.sv
// Pin engine: turns one micro-operation into one strobe cycle, or one wait for ready, on the pins.
// Assumes the byte bus and ready/busy come from the pins, outside this domain.
`timescale 1ns/100ps
module nfc_pin_engine
  import nfc_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Operation port
  nfc_op_if.eng           opi,
  // Pins
  output logic            cmd_latch_q,
  output logic            addr_latch_q,
  output logic            in_strobe_n_q,
  output logic            output_strobe_n_q,
  output logic [7:0]      bus_out_q,
  output logic            bus_oe_n_q,
  input  wire logic [7:0] byte_bus_in,
  input  wire logic       ready_busy_n_in
);
  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  logic [7:0] bus_s1_q, bus_s2_q;   // Byte bus, two stages
  logic       rb_s1_q, rb_s2_q;     // Ready/busy, two stages

  // Two flops before any logic looks at the pins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus_s1_q <= 8'h00;
      bus_s2_q <= 8'h00;
      rb_s1_q  <= 1'b1;
      rb_s2_q  <= 1'b1;
    end else begin
      bus_s1_q <= byte_bus_in;
      bus_s2_q <= bus_s1_q;
      rb_s1_q  <= ready_busy_n_in;
      rb_s2_q  <= rb_s1_q;
    end
  end

  // -----------------------------------------------------------------
  // Cycle state machine
  // -----------------------------------------------------------------
  typedef enum logic [5:0] {
    NFC_E_IDLE  = 6'b000001,
    NFC_E_SETUP = 6'b000010,
    NFC_E_LOW   = 6'b000100,
    NFC_E_HIGH  = 6'b001000,
    NFC_E_WB    = 6'b010000,
    NFC_E_BUSY  = 6'b100000
  } nfc_eng_t;
  nfc_eng_t          st_q;      // Engine state
  nfc_op_t           op_q;      // Captured operation
  logic [TCNT_W-1:0] cnt_q;     // Phase timer
  logic              rd_op;     // Current op is a read

  assign opi.ready = (st_q == NFC_E_IDLE);
  assign rd_op     = (op_q == NFC_OP_RD);

  // Sequence one strobe cycle or one wait for ready
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q              <= NFC_E_IDLE;
      op_q              <= NFC_OP_CMD;
      cnt_q             <= '0;
      cmd_latch_q       <= 1'b0;
      addr_latch_q      <= 1'b0;
      in_strobe_n_q     <= 1'b1;
      output_strobe_n_q <= 1'b1;
      bus_out_q         <= 8'h00;
      bus_oe_n_q        <= 1'b1;
      opi.done          <= 1'b0;
      opi.rdata         <= 8'h00;
    end else begin
      opi.done <= 1'b0;
      unique case (st_q)
        NFC_E_IDLE: begin
          if (opi.valid) begin
            op_q         <= opi.op;
            // Latch lines set the cycle type with setup before the strobe
            cmd_latch_q  <= (opi.op == NFC_OP_CMD);
            addr_latch_q <= (opi.op == NFC_OP_ADDR);
            bus_out_q    <= opi.wdata;
            bus_oe_n_q   <= (opi.op == NFC_OP_RD) || (opi.op == NFC_OP_WAIT);
            // Every read waits the longer write-to-read gap
            cnt_q        <= TCNT_W'((opi.op == NFC_OP_RD) ? CYC_WHR : CYC_SU);
            st_q         <= (opi.op == NFC_OP_WAIT) ? NFC_E_WB : NFC_E_SETUP;
            if (opi.op == NFC_OP_WAIT)
              cnt_q <= TCNT_W'(CYC_WB);
          end
        end
        NFC_E_SETUP: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            // Only one strobe toggles per cycle, the other stays high
            if (rd_op) output_strobe_n_q <= 1'b0;
            else      in_strobe_n_q     <= 1'b0;
            cnt_q <= TCNT_W'(rd_op ? CYC_RP : CYC_WP);
            st_q  <= NFC_E_LOW;
          end
        end
        NFC_E_LOW: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            // Device latches on the rising input strobe
            in_strobe_n_q     <= 1'b1;
            output_strobe_n_q <= 1'b1;
            // Sample data held past the access time
            if (rd_op) opi.rdata <= bus_s2_q;
            cnt_q <= TCNT_W'(CYC_WH);
            st_q  <= NFC_E_HIGH;
          end
        end
        NFC_E_HIGH: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            cmd_latch_q  <= 1'b0;
            addr_latch_q <= 1'b0;
            opi.done     <= 1'b1;
            st_q         <= NFC_E_IDLE;
          end
        end
        NFC_E_WB: begin
          // Give the device time to pull busy low after a confirm or a reset code
          if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
          else begin
            cnt_q <= TCNT_W'(CYC_TR);
            st_q  <= NFC_E_BUSY;
          end
        end
        NFC_E_BUSY: begin
          // Strobes stay high until ready/busy is released
          if (!rb_s2_q) cnt_q <= TCNT_W'(CYC_TR);
          else if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
          else begin
            opi.done <= 1'b1;
            st_q     <= NFC_E_IDLE;
          end
        end
        default: st_q <= NFC_E_IDLE;
      endcase
    end
  end
endmodule // nfc_pin_engine

//--- src/nfc_host.sv
// Host controller for a page-organised NAND flash: builds command, address
// and data cycles for each user sequence and drives the device pins.
// Assumes a single 125 MHz clock; device pins are asynchronous to it and the
// board pulls the open-drain ready/busy line up.
`timescale 1ns/100ps
module nfc_host
  import nfc_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rstn,
  // User request
  input  wire logic                req_valid,
  output logic                     req_ready_q,
  input  wire nfc_seq_t            req_seq,
  input  wire logic [7:0]          req_cmd1,      // First code (80/81/8C/00/70/71/raw)
  input  wire logic [7:0]          req_cmd2,      // Confirm code (10/15/11/30/31/3F/3A)
  input  wire logic [COL_W-1:0]    req_col,
  input  wire logic [BLOCK_W-1:0]  req_block,
  input  wire logic [PAGE_W-1:0]   req_page,
  input  wire logic [LEN_W-1:0]    req_len,       // Bytes minus one
  input  wire logic                req_write_en,  // Lifts write protect for program/erase
  // Write data stream
  input  wire logic [7:0]          wr_data,
  output logic                     wr_take_q,     // Pulse: wr_data consumed
  // Read data stream
  output logic [7:0]               rd_data_q,
  output logic                     rd_valid_q,    // Pulse per byte
  output logic                     seq_done_q,    // Pulse at sequence end
  output logic                     protect_err_q, // Pulse: program/erase refused
  // Device pins
  output logic                     chip_sel_n_q,
  output logic                     cmd_latch,
  output logic                     addr_latch,
  output logic                     in_strobe_n,
  output logic                     output_strobe_n,
  output logic                     write_prot_n_q,
  output logic [7:0]               byte_bus_out,
  output logic                     byte_bus_oe_n,
  input  wire logic [7:0]          byte_bus_in,
  input  wire logic                ready_busy_n
);
  // -----------------------------------------------------------------
  // Pin engine
  // -----------------------------------------------------------------
  nfc_op_if opi ();

  nfc_pin_engine u_eng (
    .core_clk          (core_clk),
    .rstn              (rstn),
    .opi               (opi),
    .cmd_latch_q       (cmd_latch),
    .addr_latch_q      (addr_latch),
    .in_strobe_n_q     (in_strobe_n),
    .output_strobe_n_q (output_strobe_n),
    .bus_out_q         (byte_bus_out),
    .bus_oe_n_q        (byte_bus_oe_n),
    .byte_bus_in       (byte_bus_in),
    .ready_busy_n_in   (ready_busy_n)
  );

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  typedef enum logic [7:0] {
    NFC_S_IDLE  = 8'b00000001,
    NFC_S_WW    = 8'b00000010,
    NFC_S_CMD1  = 8'b00000100,
    NFC_S_ADDR  = 8'b00001000,
    NFC_S_DATA  = 8'b00010000,
    NFC_S_CMD2  = 8'b00100000,
    NFC_S_WAIT  = 8'b01000000,
    NFC_S_READ  = 8'b10000000
  } nfc_st_t;
  nfc_st_t           st_q;        // Sequence state
  nfc_seq_t          seq_q;       // Captured request
  logic [7:0]        cmd1_q;      // First command code
  logic [7:0]        cmd2_q;      // Confirm code
  logic [COL_W-1:0]  col_q;       // Column address
  logic [ROW_W-1:0]  row_q;       // Row address
  logic [LEN_W-1:0]  len_q;       // Bytes left minus one
  logic [2:0]        aidx_q;      // Address cycle index
  logic [2:0]        alast_q;     // Last address cycle index
  logic [2:0]        afirst_q;    // First address cycle index
  logic              issued_q;    // Current op handed to engine
  logic [TCNT_W-1:0] ww_q;        // Write-protect release timer

  // Whether a sequence changes the array
  function automatic logic nfc_is_write(input nfc_seq_t s);
    nfc_is_write = (s == NFC_SEQ_PROG) || (s == NFC_SEQ_ERASE);
  endfunction

  // Engine request for the current state
  always_comb begin
    opi.valid = 1'b0;
    opi.op    = NFC_OP_CMD;
    opi.wdata = 8'h00;
    unique case (st_q)
      NFC_S_CMD1: begin
        opi.valid = !issued_q;
        opi.wdata = cmd1_q;
      end
      NFC_S_ADDR: begin
        // Column bytes, then page and block in the row
        opi.valid = !issued_q;
        opi.op    = NFC_OP_ADDR;
        opi.wdata = (seq_q == NFC_SEQ_ID) ? 8'h00 : nfc_addr_byte(col_q, row_q, aidx_q);
      end
      NFC_S_DATA: begin
        opi.valid = !issued_q;
        opi.op    = NFC_OP_WR;
        opi.wdata = wr_data;
      end
      NFC_S_CMD2: begin
        opi.valid = !issued_q;
        opi.wdata = cmd2_q;
      end
      NFC_S_WAIT: begin
        opi.valid = !issued_q;
        opi.op    = NFC_OP_WAIT;
      end
      NFC_S_READ: begin
        // Each output strobe fall moves the device column by one
        opi.valid = !issued_q;
        opi.op    = NFC_OP_RD;
      end
      default: opi.valid = 1'b0;
    endcase
  end

  // Step through the cycles of a sequence
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q      <= NFC_S_IDLE;
      seq_q     <= NFC_SEQ_RESET;
      cmd1_q    <= CMD_RESET;
      cmd2_q    <= CMD_READ2;
      col_q     <= '0;
      row_q     <= '0;
      len_q     <= '0;
      aidx_q    <= 3'h0;
      alast_q   <= 3'h0;
      afirst_q  <= 3'h0;
      issued_q  <= 1'b0;
      ww_q      <= '0;
      wr_take_q <= 1'b0;
      rd_valid_q    <= 1'b0;
      rd_data_q     <= 8'h00;
      seq_done_q    <= 1'b0;
      protect_err_q <= 1'b0;
    end else begin
      wr_take_q     <= 1'b0;
      rd_valid_q    <= 1'b0;
      seq_done_q    <= 1'b0;
      protect_err_q <= 1'b0;
      if (opi.valid && opi.ready) issued_q <= 1'b1;
      if (opi.done) issued_q <= 1'b0;
      unique case (st_q)
        NFC_S_IDLE: begin
          if (req_valid) begin
            seq_q  <= req_seq;
            col_q  <= req_col;
            row_q  <= {req_block, req_page};
            len_q  <= req_len;
            cmd2_q <= req_cmd2;
            ww_q   <= TCNT_W'(CYC_WW);
            // Fixed opening codes for erase, reset, ID and column read; others take req_cmd1
            unique case (req_seq)
              NFC_SEQ_READ:  cmd1_q <= req_cmd1;
              NFC_SEQ_PROG:  cmd1_q <= req_cmd1;
              NFC_SEQ_ERASE: cmd1_q <= CMD_ERASE1;
              NFC_SEQ_RESET: cmd1_q <= CMD_RESET;
              NFC_SEQ_ID:    cmd1_q <= CMD_ID;
              NFC_SEQ_RCOL:  cmd1_q <= CMD_RCOL1;
              default:       cmd1_q <= req_cmd1;
            endcase
            if (req_seq == NFC_SEQ_ERASE) cmd2_q <= CMD_ERASE2;
            if (req_seq == NFC_SEQ_RCOL)  cmd2_q <= CMD_RCOL2;
            // Erase sends only the three row cycles
            afirst_q <= (req_seq == NFC_SEQ_ERASE) ? 3'd2 : 3'd0;
            aidx_q   <= (req_seq == NFC_SEQ_ERASE) ? 3'd2 : 3'd0;
            alast_q  <= (req_seq == NFC_SEQ_RCOL) ? 3'd1 :
                        (req_seq == NFC_SEQ_ID) ? 3'd0 : 3'(ADDR_CYCLES - 1);
            // Program and erase refused unless write enabled
            if (nfc_is_write(req_seq) && !req_write_en) protect_err_q <= 1'b1;
            else st_q <= nfc_is_write(req_seq) ? NFC_S_WW : NFC_S_CMD1;
          end
        end
        NFC_S_WW: begin
          // Write protect must be high a while before the first strobe
          if (ww_q != '0) ww_q <= ww_q - 1'b1;
          else st_q <= NFC_S_CMD1;
        end
        NFC_S_CMD1: begin
          if (opi.done) begin
            unique case (seq_q)
              NFC_SEQ_RESET:  st_q <= NFC_S_WAIT;
              NFC_SEQ_STATUS: st_q <= NFC_S_READ;
              NFC_SEQ_RAW: begin
                seq_done_q <= 1'b1;
                st_q       <= NFC_S_IDLE;
              end
              default:        st_q <= NFC_S_ADDR;
            endcase
            len_q <= (seq_q == NFC_SEQ_STATUS) ? '0 : len_q;
          end
        end
        NFC_S_ADDR: begin
          if (opi.done) begin
            aidx_q <= aidx_q + 3'd1;
            if (aidx_q == alast_q) begin
              unique case (seq_q)
                NFC_SEQ_PROG: st_q <= NFC_S_DATA;
                NFC_SEQ_ID:   st_q <= NFC_S_READ;
                default:      st_q <= NFC_S_CMD2;
              endcase
            end
          end
        end
        NFC_S_DATA: begin
          if (opi.done) begin
            wr_take_q <= 1'b1;
            len_q     <= len_q - 1'b1;
            if (len_q == '0) st_q <= NFC_S_CMD2;
          end
        end
        NFC_S_CMD2: begin
          // Confirm starts the array operation; for a column read, e0 goes straight to reading
          if (opi.done) st_q <= (seq_q == NFC_SEQ_RCOL) ? NFC_S_READ : NFC_S_WAIT;
        end
        NFC_S_WAIT: begin
          // Chip select held low through busy; device ignores it anyway
          if (opi.done) begin
            if (seq_q == NFC_SEQ_READ) st_q <= NFC_S_READ;
            else begin
              seq_done_q <= 1'b1;
              st_q       <= NFC_S_IDLE;
            end
          end
        end
        NFC_S_READ: begin
          if (opi.done) begin
            rd_data_q  <= opi.rdata;
            rd_valid_q <= 1'b1;
            len_q      <= len_q - 1'b1;
            if (len_q == '0) begin
              seq_done_q <= 1'b1;
              st_q       <= NFC_S_IDLE;
            end
          end
        end
        default: st_q <= NFC_S_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Chip select, write protect, request ready
  // -----------------------------------------------------------------
  // Deselect when idle so the ready device drops to standby
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      chip_sel_n_q   <= 1'b1;
      write_prot_n_q <= 1'b0;
      req_ready_q    <= 1'b0;
    end else begin
      chip_sel_n_q   <= (st_q == NFC_S_IDLE) && !req_valid;
      write_prot_n_q <= (st_q != NFC_S_IDLE) && nfc_is_write(seq_q);
      req_ready_q    <= (st_q == NFC_S_IDLE) && !req_valid;
    end
  end
endmodule // nfc_host

//--- dv/nfc_host_chk.sv
// Checker for the host controller pins and user pulses.
// Assumes it is bound to the host top and sees its ports only.
`timescale 1ns/100ps
module nfc_host_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Device pins
  input wire logic chip_sel_n_q,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic in_strobe_n,
  input wire logic output_strobe_n,
  input wire logic byte_bus_oe_n,
  input wire logic ready_busy_n,
  // User side
  input wire logic req_ready_q,
  input wire logic rd_valid_q,
  input wire logic protect_err_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_latch_excl: assert property (!(cmd_latch && addr_latch))
    else $error("Both latch lines high");
  chk_strobe_excl: assert property (!(!in_strobe_n && !output_strobe_n))
    else $error("Both strobes low");
  chk_cs_strobe: assert property (!in_strobe_n || !output_strobe_n |-> !chip_sel_n_q)
    else $error("Strobe without chip select");
  chk_read_float: assert property (!output_strobe_n |-> byte_bus_oe_n)
    else $error("Host drives bus during read");
  chk_cmd_drive: assert property (cmd_latch && !in_strobe_n |-> !byte_bus_oe_n)
    else $error("Command byte not driven");
  chk_refuse_quiet: assert property (protect_err_q |-> in_strobe_n ##1 in_strobe_n)
    else $error("Strobe after refusal");
  chk_busy_quiet: assert property (!ready_busy_n [*3] |-> in_strobe_n && output_strobe_n)
    else $error("Strobe while busy");
  chk_we_width: assert property ($fell(in_strobe_n) |=> !in_strobe_n)
    else $error("Input strobe too short");
  chk_rd_pulse: assert property (rd_valid_q |=> !rd_valid_q)
    else $error("Read pulses too close");
  chk_idle_desel: assert property (req_ready_q |-> chip_sel_n_q && in_strobe_n && output_strobe_n)
    else $error("Chip selected while idle");
endmodule // nfc_host_chk

//--- dv/nfc_dev_model.sv
// Behavioural flash device seen from its pins.
// Assumes the ready/busy line is pulled up, so it idles high.
`timescale 1ns/100ps
module nfc_dev_model (
  // Host pins
  input  wire logic       cs_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] din,
  // Device outputs
  output logic [7:0]      dout,
  output logic            rb_n
);
  logic [7:0]  cmds[$], adrs[$]; // Latched codes and address bytes
  logic [11:0] col = 0;          // Column counter
  logic [7:0]  q = 0;            // Last byte put out
  int          ndat = 0;         // Data bytes taken
  initial rb_n = 1;
  // Latch on input strobe rise; busy only after a confirm or a reset
  always @(posedge we_n) if (!cs_n) begin
    if (cle) cmds.push_back(din);
    else if (ale) begin
      adrs.push_back(din);
      if (adrs.size() == 1) col[7:0] = din;
      if (adrs.size() == 2) col[11:8] = din[3:0];
    end else if (wp_n) ndat++;
    if (cle && (din inside {8'h30, 8'h31, 8'h3f, 8'h3a, 8'hff}
        || wp_n && din inside {8'h10, 8'h15, 8'h11, 8'hd0}))
      fork begin #50 rb_n = 0; #400 rb_n = 1; end join_none
  end
  // Next byte and column step on strobe fall
  always @(negedge re_n) begin q = col[7:0]; col++; end
  // Released bus shows the inverse, never a stale value
  assign dout = (!re_n && !cs_n) ? q : ~q;
endmodule // nfc_dev_model

//--- dv/nfc_host_tb.sv
// Self-checking bench for the host controller with a device model.
// Assumes the package constants and a 125 MHz clock.
`timescale 1ns/100ps
module nfc_host_tb;
  import nfc_pkg::*;
  logic core_clk, rstn, req_valid, req_ready_q, req_write_en, wr_take_q, rd_valid_q, seq_done_q;
  logic protect_err_q, chip_sel_n_q, cmd_latch, addr_latch, in_strobe_n, output_strobe_n;
  logic write_prot_n_q, byte_bus_oe_n, ready_busy_n;
  nfc_seq_t req_seq;
  logic [7:0] req_cmd1, req_cmd2, wr_data, rd_data_q, byte_bus_out, byte_bus_in, rd[$];
  logic [COL_W-1:0] req_col;
  logic [BLOCK_W-1:0] req_block;
  logic [PAGE_W-1:0] req_page;
  logic [LEN_W-1:0] req_len;
  int mismatches = 0, compares = 0, gerr, ntake;
  initial begin core_clk = 0; forever #4 core_clk = ~core_clk; end
  nfc_host DUT (.*);
  nfc_dev_model m (.cs_n(chip_sel_n_q), .cle(cmd_latch), .ale(addr_latch), .we_n(in_strobe_n),
    .re_n(output_strobe_n), .wp_n(write_prot_n_q), .din(byte_bus_out), .dout(byte_bus_in),
    .rb_n(ready_busy_n));
  task chk(input logic [39:0] g, e);
    compares++;
    if (g !== e) begin mismatches++; $display("FAIL t=%0t got %h exp %h", $time, g, e); end
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One request, bounded wait for done or refusal
  task run(input nfc_seq_t s, input logic [7:0] c1, c2, input logic [11:0] col,
           input logic [10:0] blk, input logic [5:0] pg, input logic [11:0] len, input logic we);
    m.cmds.delete(); m.adrs.delete(); m.ndat = 0; rd.delete(); gerr = 0; ntake = 0;
    @(negedge core_clk);
    while (req_ready_q !== 1) @(negedge core_clk);
    {req_seq, req_cmd1, req_cmd2, req_col, req_block, req_page} = {s, c1, c2, col, blk, pg};
    {req_len, req_write_en, req_valid} = {len, we, 1'b1};
    @(negedge core_clk);
    req_valid = 0;
    gerr = (protect_err_q === 1);
    for (int i = 0; i < 5000 && seq_done_q !== 1 && gerr == 0; i++) begin
      @(negedge core_clk);
      if (rd_valid_q === 1) rd.push_back(rd_data_q);
      if (wr_take_q === 1) ntake++;
      if (protect_err_q === 1) gerr = 1;
    end
    chk(seq_done_q | gerr[0], 1);
  endtask
  task t_read; // Each read confirm, last four columns of the top page
    static logic [7:0] rc[4] = '{8'h30, 8'h31, 8'h3f, 8'h3a};
    for (int k = 0; k < 4; k++) begin
      run(NFC_SEQ_READ, 8'h00, rc[k], 12'h87c, 11'h7ff, 6'h3f, 12'h003, 1'b0);
      chk({m.cmds[0], m.cmds[1]}, {8'h00, req_cmd2});
      chk({m.adrs[0], m.adrs[1], m.adrs[2], m.adrs[3], m.adrs[4]}, 40'h7c08ffff01);
      chk({rd[0], rd[1], rd[2], rd[3], 8'(rd.size())}, 40'h7c7d7e7f04);
    end
    $display("read done");
  endtask
  task t_prog; // Program pairs, then a refusal with protect held
    static logic [7:0] c1[3] = '{8'h80, 8'h81, 8'h8c}, c2[3] = '{8'h11, 8'h10, 8'h15};
    for (int k = 0; k < 3; k++) begin
      run(NFC_SEQ_PROG, c1[k], c2[k], 12'h000, 11'h001, 6'h02, 12'h001, 1'b1);
      chk({m.cmds[0], m.cmds[1]}, {c1[k], c2[k]});
      chk({m.adrs[0], m.adrs[1], m.adrs[2], m.adrs[3], m.adrs[4]}, 40'h0000420000);
      chk({m.ndat[7:0], ntake[7:0]}, 16'h0202);
    end
    run(NFC_SEQ_PROG, 8'h80, 8'h10, 12'h000, 11'h001, 6'h02, 12'h001, 1'b0);
    chk({gerr[7:0], 8'(m.cmds.size())}, 16'h0100);
    $display("program done");
  endtask
  task t_erase; // Block erase sends row bytes only
    run(NFC_SEQ_ERASE, 8'h60, 8'hd0, 12'h000, 11'h002, 6'h00, 12'h000, 1'b1);
    chk({m.cmds[0], m.cmds[1], 8'(m.adrs.size())}, 24'h60d003);
    chk({m.adrs[0], m.adrs[1], m.adrs[2]}, 24'h800000);
    $display("erase done");
  endtask
  task t_status; // Both status codes, then reset, ID, column read and one raw code
    run(NFC_SEQ_STATUS, 8'h70, 8'h00, 0, 0, 0, 12'h000, 1'b0);
    chk({m.cmds[0], 8'(rd.size())}, 16'h7001);
    run(NFC_SEQ_STATUS, 8'h71, 8'h00, 0, 0, 0, 12'h000, 1'b0);
    chk({m.cmds[0], 8'(rd.size())}, 16'h7101);
    run(NFC_SEQ_RESET, 8'hff, 8'h00, 0, 0, 0, 12'h000, 1'b0);
    chk(m.cmds[0], 8'hff);
    run(NFC_SEQ_ID, 8'h90, 8'h00, 0, 0, 0, 12'h001, 1'b0);
    chk({m.cmds[0], m.adrs[0], 8'(rd.size())}, 24'h900002);
    run(NFC_SEQ_RCOL, 8'h05, 8'he0, 12'h010, 0, 0, 12'h000, 1'b0);
    chk({m.cmds[0], m.cmds[1], m.adrs[0], m.adrs[1], rd[0]}, 40'h05e0100010);
    run(NFC_SEQ_RAW, 8'h85, 8'h00, 0, 0, 0, 12'h000, 1'b0);
    chk({m.cmds[0], 8'(m.cmds.size())}, 16'h8501);
    $display("status done");
  endtask
  initial begin
    {rstn, req_valid, req_write_en, req_seq, req_cmd1, req_cmd2, wr_data} = 0;
    {req_col, req_block, req_page, req_len} = 0;
    wr_data = 8'h5a;
    repeat (16) @(negedge core_clk);
    rstn = 1;
    chk({chip_sel_n_q, write_prot_n_q}, 2'b10);
    t_read;
    t_prog;
    t_erase;
    t_status;
    conclude;
  end
  initial begin #400000; mismatches++; conclude; end
endmodule // nfc_host_tb
bind nfc_host nfc_host_chk chk (.*);
